// [rtl/adc_output_format_config.sv]
// Summary of operation
// - Clock position bit 1 delays the output clock by one core clock (400 ps rounded up).
// - Clock edge bit picks rising (0) or falling (1) capture edge.
// - Data position bit 1 delays data transitions by half a clock.
// - Bit/byte sequencing applies only in DDR mode.
// - Bit-wise: even bits on rising edge, odd bits on falling edge.
// - Byte-wise: low half on rising edge, high half on falling edge.
// - Pattern 000 passes samples, 001 all zeros, 010 all ones.
// - Pattern 011 alternates 0x2AAA and 0x1555 each output word.
// - Pattern 100 ramps from zero up by one per word.
// - Pattern 101 outputs the custom word; 110 and 111 unused.
// - Coding bit 0 gives two's complement, 1 offset binary.
// - Custom bits 6..0 come from register 0B bits 10..4.
// - Custom bits 11..7 come from register 0C bits 4..0.
// - Current code 00/01/10/11 gives 3.5/2.5/4.5/1.75 mA.
// - Bit 0 doubles data buffer current, bit 1 clock buffer current.
// - Data termination: 000 off, then 300..65 ohms.
// - Clock termination uses the same eight codes.
`include "adc_fmt_params.svh"
module adc_output_format_config
    import adc_fmt_pkg::*;
#(
    parameter int QUARTER   = 2,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Serial configuration pins
    input  wire logic              cfg_sclk,
    input  wire logic              cfg_sdata,
    input  wire logic              cfg_sen_n,
    input  wire logic              cfg_reset,
    // Converter samples, offset binary
    input  wire logic              sample_valid,
    input  wire logic [11:0]       sample_data,
    output logic                   sample_ready,
    // Interface mode and capture stall
    input  wire logic              ddr_mode,
    input  wire logic              capture_ready,
    // Output port
    output logic                   out_clock_true,
    output logic [13:0]            data_out,
    // Analog settings
    output analog_cfg_t            analog_cfg,
    output logic [2:0]             gain_db
);
    localparam int PW = $clog2(BUF_DEPTH);
    localparam int DLY = `CLK_SHIFT_CYC;

    if (QUARTER < 1 || BUF_DEPTH != 2) begin : g_bad
        $error("Unsupported QUARTER or BUF_DEPTH");
    end

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [3:0] pin_in;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] pin_lvl;
    assign pin_in = {cfg_reset, cfg_sen_n, cfg_sdata, cfg_sclk};

    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (!resetn) begin
                sync1[i]   <= 1'b0;
                sync2[i]   <= 1'b0;
                sync3[i]   <= 1'b0;
                pin_lvl[i] <= 1'b0;
            end else begin
                sync1[i] <= pin_in[i];
                sync2[i] <= sync1[i];
                sync3[i] <= sync2[i];
                if (sync2[i] == sync3[i]) begin
                    pin_lvl[i] <= sync3[i];
                end
            end
        end
    end

    logic sclk_rise;
    logic hw_reset;
    logic sen_idle;
    assign sclk_rise = sync2[0] & sync3[0] & ~pin_lvl[0];
    assign sen_idle  = pin_lvl[2];
    assign hw_reset  = pin_lvl[3];

    // ************************************************
    // Serial shift register, address then data, MSB first
    // ************************************************
    ser_state_t ser_state;
    logic [14:0] shift;
    logic [3:0]  bit_cnt;
    logic        wr_stb;
    logic [15:0] wr_word;
    assign wr_word = {shift, sync3[1]};
    assign wr_stb  = sclk_rise && !sen_idle && bit_cnt == 4'(`SER_WORD_BITS - 1);

    always_ff @(posedge clk) begin
        if (!resetn || sen_idle) begin
            ser_state <= SER_WAIT;
            bit_cnt   <= 4'h0;
            shift     <= 15'h0000;
        end else if (sclk_rise) begin
            ser_state <= SER_SHIFT;
            shift     <= wr_word[14:0];
            bit_cnt   <= bit_cnt + 4'h1;
        end
    end

    // ************************************************
    // Register file
    // ************************************************
    localparam logic [4:0]  REG_ADDR [6] = '{`ADDR_TIMING, `ADDR_DDR_SEQ,
        `ADDR_FORMAT, `ADDR_CUST_LO, `ADDR_GAIN_HI, `ADDR_LVDS};
    localparam logic [10:0] REG_MASK [6] = '{`MASK_TIMING, `MASK_DDR_SEQ,
        `MASK_FORMAT, `MASK_CUST_LO, `MASK_GAIN_HI, `MASK_LVDS};
    logic [10:0] cfg_reg [6];

    // Fixed-zero bits are masked so a careless write cannot reach them
    for (genvar r = 0; r < 6; r++) begin : g_reg
        always_ff @(posedge clk) begin
            if (!resetn || hw_reset) begin
                cfg_reg[r] <= `REG_RESET;
            end else if (wr_stb && wr_word[15:11] == REG_ADDR[r]) begin
                cfg_reg[r] <= wr_word[10:0] & REG_MASK[r];
            end
        end
    end

    logic        clk_pos;
    logic        clk_edge;
    logic        data_pos;
    logic        byte_wise;
    logic        coding;
    logic [2:0]  pattern;
    logic [11:0] custom;
    assign clk_pos   = cfg_reg[0][`BIT_CLK_POS];
    assign clk_edge  = cfg_reg[0][`BIT_CLK_EDGE];
    assign data_pos  = cfg_reg[0][`BIT_DATA_POS];
    assign byte_wise = cfg_reg[1][`BIT_BYTE_WISE] & ddr_mode;
    assign coding    = cfg_reg[2][`BIT_CODING];
    assign pattern   = cfg_reg[2][`PAT_MSB:`PAT_LSB];
    assign custom    = {cfg_reg[4][4:0], cfg_reg[3][10:4]};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            analog_cfg <= '0;
            gain_db    <= 3'h0;
        end else begin
            analog_cfg.data_double  <= cfg_reg[5][0];
            analog_cfg.clk_double   <= cfg_reg[5][1];
            analog_cfg.lvds_current <= cfg_reg[5][3:2];
            analog_cfg.clk_term     <= cfg_reg[5][6:4];
            analog_cfg.data_term    <= cfg_reg[5][9:7];
            analog_cfg.fine_gain    <= cfg_reg[4][10:8];
            // Unused gain code falls back to 0 dB
            gain_db <= (cfg_reg[4][10:8] == 3'h7) ? 3'h0 : cfg_reg[4][10:8];
        end
    end

    // ************************************************
    // Two-entry sample buffer
    // ************************************************
    logic [11:0]   buf_mem [BUF_DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   buf_cnt;
    logic          buf_valid;
    logic          pop;
    logic          push;
    assign buf_valid    = buf_cnt != '0;
    assign sample_ready = buf_cnt != (PW+1)'(BUF_DEPTH);
    assign push         = sample_valid && sample_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            buf_mem[wr_ptr] <= sample_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            buf_cnt <= '0;
        end else begin
            wr_ptr  <= wr_ptr + PW'(push);
            rd_ptr  <= rd_ptr + PW'(pop);
            buf_cnt <= buf_cnt + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // ************************************************
    // Output clock, four quarters per output cycle
    // ************************************************
    logic [15:0]  sub_cnt;
    logic [1:0]   quarter;
    logic         q_start;
    logic         clk_raw;
    logic [DLY:0] clk_line;
    assign q_start = sub_cnt == 16'h0000;
    assign clk_raw = (quarter < 2'h2) ^ clk_edge;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sub_cnt <= 16'h0000;
            quarter <= 2'h0;
        end else if (sub_cnt == 16'(QUARTER - 1)) begin
            sub_cnt <= 16'h0000;
            quarter <= quarter + 2'h1;
        end else begin
            sub_cnt <= sub_cnt + 16'h0001;
        end
    end

    // Delay rounds up to a whole core clock, the finest step the core clock can make
    always_ff @(posedge clk) begin
        if (!resetn) begin
            clk_line       <= '0;
            out_clock_true <= 1'b0;
        end else begin
            clk_line       <= {clk_line[DLY-1:0], clk_raw};
            out_clock_true <= clk_pos ? clk_line[DLY-1] : clk_raw;
        end
    end

    // ************************************************
    // Word formation and test patterns
    // ************************************************
    logic [1:0]  load_q;
    logic        word_load;
    logic        half_load;
    logic        advance;
    logic [11:0] coded;
    logic [13:0] sample_word;
    logic [13:0] next_word;
    logic [13:0] word_reg;
    logic [13:0] ramp_cnt;
    logic        tog;

    // In DDR mode or with data position 0, data launch sits mid-way between capture edges
    assign load_q    = (ddr_mode ? 2'h3 : 2'h2) + (data_pos ? 2'h2 : 2'h0);
    assign word_load = q_start && quarter == load_q;
    assign half_load = q_start && ddr_mode && quarter == load_q + 2'h2;
    assign advance   = word_load && capture_ready &&
                       (pattern != `PAT_NORMAL || buf_valid);
    assign pop       = advance && buf_valid;

    always_comb begin
        coded = coding ? buf_mem[rd_ptr] : {~buf_mem[rd_ptr][11], buf_mem[rd_ptr][10:0]};
        sample_word = coding ? {2'b00, coded} : {{2{coded[11]}}, coded};
        unique case (pattern)
            `PAT_ZEROS:  next_word = 14'h0000;
            `PAT_ONES:   next_word = `WORD_ONES;
            `PAT_TOGGLE: next_word = tog ? `WORD_TOG_B : `WORD_TOG_A;
            `PAT_RAMP:   next_word = ramp_cnt;
            `PAT_CUSTOM: next_word = {2'b00, custom};
            default:     next_word = sample_word;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            word_reg <= 14'h0000;
            ramp_cnt <= 14'h0000;
            tog      <= 1'b0;
        end else if (advance) begin
            word_reg <= next_word;
            tog      <= (pattern == `PAT_TOGGLE) ? ~tog : 1'b0;
            // Natural 14-bit wrap gives the return to zero
            ramp_cnt <= (pattern == `PAT_RAMP) ? ramp_cnt + 14'h0001 : 14'h0000;
        end
    end

    // ************************************************
    // DDR lane sequencing
    // ************************************************
    logic [6:0] even_bits;
    logic [6:0] odd_bits;
    logic [6:0] even_new;
    for (genvar k = 0; k < 7; k++) begin : g_lane
        assign even_bits[k] = word_reg[2*k];
        assign odd_bits[k]  = word_reg[2*k+1];
        assign even_new[k]  = next_word[2*k];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_out <= 14'h0000;
        end else if (word_load) begin
            if (!ddr_mode) begin
                data_out <= advance ? next_word : word_reg;
            end else if (byte_wise) begin
                data_out <= {7'h00, advance ? next_word[6:0] : word_reg[6:0]};
            end else begin
                data_out <= {7'h00, advance ? even_new : even_bits};
            end
        end else if (half_load) begin
            data_out <= {7'h00, byte_wise ? word_reg[13:7] : odd_bits};
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_ramp_step;
        advance && pattern == `PAT_RAMP;
    endsequence

    property p_zeros;
        advance && pattern == `PAT_ZEROS |=> word_reg == 14'h0000;
    endproperty
    a_zeros: assert property (p_zeros) else $error("zero pattern wrong");

    property p_ones;
        advance && pattern == `PAT_ONES |=> word_reg == `WORD_ONES;
    endproperty
    a_ones: assert property (p_ones) else $error("ones pattern wrong");

    property p_toggle;
        advance && pattern == `PAT_TOGGLE && tog |=> word_reg == `WORD_TOG_B;
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle wrong");

    // Ramp steps are a whole output cycle apart, so the next step is
    // checked through the counter that will feed it
    property p_ramp;
        s_ramp_step |=> ramp_cnt == word_reg + 14'h0001;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp step wrong");

    property p_custom;
        advance && pattern == `PAT_CUSTOM |=>
            word_reg == {2'b00, $past(cfg_reg[4][4:0]), $past(cfg_reg[3][10:4])};
    endproperty
    a_custom: assert property (p_custom) else $error("custom wrong");

    property p_coding;
        pop && pattern == `PAT_NORMAL && !coding |=>
            word_reg[13:11] == {3{~$past(buf_mem[rd_ptr][11])}};
    endproperty
    a_coding: assert property (p_coding) else $error("coding wrong");

    property p_posn;
        word_load && !ddr_mode |-> quarter == (data_pos ? 2'h0 : 2'h2);
    endproperty
    a_posn: assert property (p_posn) else $error("data position wrong");

    property p_clk_edge;
        q_start && quarter == 2'h0 && !clk_pos |=> out_clock_true == !$past(clk_edge);
    endproperty
    a_clk_edge: assert property (p_clk_edge) else $error("clock edge wrong");

    property p_byte_hi;
        half_load && byte_wise |=> data_out[6:0] == $past(word_reg[13:7]);
    endproperty
    a_byte_hi: assert property (p_byte_hi) else $error("byte lane wrong");

    property p_gain;
        cfg_reg[4][10:8] != 3'h7 |=> gain_db == $past(cfg_reg[4][10:8]);
    endproperty
    a_gain: assert property (p_gain) else $error("fine gain wrong");
endmodule

// [inc/adc_fmt_params.svh]
`ifndef ADC_FMT_PARAMS_SVH
`define ADC_FMT_PARAMS_SVH
// Register addresses on the serial port
`define ADDR_TIMING    5'h04
`define ADDR_DDR_SEQ   5'h09
`define ADDR_FORMAT    5'h0A
`define ADDR_CUST_LO   5'h0B
`define ADDR_GAIN_HI   5'h0C
`define ADDR_LVDS      5'h0E
// Writable bits; all others are fixed zero
`define MASK_TIMING    11'h700
`define MASK_DDR_SEQ   11'h400
`define MASK_FORMAT    11'h4E0
`define MASK_CUST_LO   11'h7F0
`define MASK_GAIN_HI   11'h71F
`define MASK_LVDS      11'h3FF
`define REG_RESET      11'h000
// Field positions
`define BIT_CLK_POS    8
`define BIT_CLK_EDGE   9
`define BIT_DATA_POS   10
`define BIT_BYTE_WISE  10
`define BIT_CODING     10
`define PAT_MSB        7
`define PAT_LSB        5
// Test pattern codes
`define PAT_NORMAL     3'h0
`define PAT_ZEROS      3'h1
`define PAT_ONES       3'h2
`define PAT_TOGGLE     3'h3
`define PAT_RAMP       3'h4
`define PAT_CUSTOM     3'h5
`define WORD_ONES      14'h3FFF
`define WORD_TOG_A     14'h2AAA
`define WORD_TOG_B     14'h1555
// Timing
`define CLK_PERIOD_PS  4000
`define CLK_SHIFT_PS   400
`define CLK_SHIFT_CYC  ((`CLK_SHIFT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SER_WORD_BITS  16
`endif

// [inc/adc_fmt_pkg.sv]
package adc_fmt_pkg;
    typedef struct packed {
        logic       data_double;
        logic       clk_double;
        logic [1:0] lvds_current;
        logic [2:0] data_term;
        logic [2:0] clk_term;
        logic [2:0] fine_gain;
    } analog_cfg_t;
    typedef enum logic {SER_WAIT, SER_SHIFT} ser_state_t;
endpackage

// [testbench/capture_rx.sv]
// ****************************************
// Capture receiver at the output port
// ****************************************
module capture_rx (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Device port
    input  wire logic        out_clock_true,
    input  wire logic [13:0] data_out,
    output logic             capture_ready,
    // Setup
    input  wire logic        fall_edge,
    input  wire logic        ddr_mode,
    input  wire logic        byte_wise,
    input  wire logic        stall_en,
    // Captured words
    output logic             cap_strobe,
    output logic [13:0]      cap_word
);
    timeunit 1ns;
    timeprecision 1ps;
    int          seed = 32'h43F8;
    logic        last_clk;
    logic [6:0]  rise_lanes;
    logic [13:0] word_ddr;
    wire         rise_ev = out_clock_true & ~last_clk;
    wire         fall_ev = ~out_clock_true & last_clk;
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            word_ddr[2*i]   = rise_lanes[i];
            word_ddr[2*i+1] = data_out[i];
        end
        if (byte_wise) word_ddr = {data_out[6:0], rise_lanes};
    end
    // A stall skips the word that the device repeats next
    always_ff @(posedge clk) begin
        last_clk   <= out_clock_true;
        cap_strobe <= 1'b0;
        if (rise_ev) rise_lanes <= data_out[6:0];
        if (!resetn) begin
            capture_ready <= 1'b1;
        end else if (ddr_mode ? fall_ev : (fall_edge ? fall_ev : rise_ev)) begin
            cap_strobe    <= capture_ready;
            cap_word      <= ddr_mode ? word_ddr : data_out;
            capture_ready <= !stall_en || ($random(seed) > 0);
        end
    end
endmodule

// [testbench/adc_output_format_config_tb.sv]
`include "adc_fmt_params.svh"
module adc_output_format_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_fmt_pkg::*;
    localparam int Q = 1;
    localparam int P = 4 * Q;
    logic        clk, resetn, cfg_sclk, cfg_sdata, cfg_sen_n, cfg_reset;
    logic        sample_valid, sample_ready, ddr_mode, capture_ready, out_clock_true;
    logic [11:0] sample_data;
    logic [13:0] data_out, cap_word;
    logic [2:0]  gain_db;
    analog_cfg_t analog_cfg;
    logic        fall_edge, byte_wise, stall_en, cap_strobe, feed, sbin;
    int          seed, n_mismatch, n_tests, n_full;
    logic [13:0] exp_q[$];
    adc_output_format_config #(.QUARTER(Q), .BUF_DEPTH(2)) adc_output_format_config_i (
        .clk(clk), .resetn(resetn), .cfg_sclk(cfg_sclk), .cfg_sdata(cfg_sdata),
        .cfg_sen_n(cfg_sen_n), .cfg_reset(cfg_reset), .sample_valid(sample_valid),
        .sample_data(sample_data), .sample_ready(sample_ready), .ddr_mode(ddr_mode),
        .capture_ready(capture_ready), .out_clock_true(out_clock_true),
        .data_out(data_out), .analog_cfg(analog_cfg), .gain_db(gain_db));
    capture_rx capture_rx_i (
        .clk(clk), .resetn(resetn), .out_clock_true(out_clock_true), .data_out(data_out),
        .capture_ready(capture_ready), .fall_edge(fall_edge), .ddr_mode(ddr_mode),
        .byte_wise(byte_wise), .stall_en(stall_en), .cap_strobe(cap_strobe),
        .cap_word(cap_word));
    // ****************************************
    // Tasks and checks
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [13:0] fmt(input logic [11:0] s, input logic bin);
        return bin ? {2'h0, s} : {{3{~s[11]}}, s[10:0]};
    endfunction
    function automatic int md(input int x);
        return ((x % P) + P) % P;
    endfunction
    // Serial write, 80 ns per bit; a released data line falls to its pull-down
    task automatic wr(input logic [4:0] a, input logic [10:0] d);
        logic [15:0] w;
        w = {a, d};
        @(posedge clk) cfg_sen_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk) cfg_sdata <= w[i];
            repeat (9) @(posedge clk);
            cfg_sclk <= 1'b1;
            repeat (10) @(posedge clk);
            cfg_sclk <= 1'b0;
        end
        cfg_sen_n <= 1'b1;
        cfg_sdata <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic get(output logic [13:0] w);
        int k;
        k = 0;
        @(posedge clk);
        while (cap_strobe !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        if (k == 200) n_mismatch++;
        w = cap_word;
    endtask
    task automatic setpat(input logic [2:0] p);
        logic [13:0] w;
        wr(`ADDR_FORMAT, {3'h0, p, 5'h00});
        repeat (3) get(w);
    endtask
    // Clocks from a data change to the next edge towards lvl
    task automatic phase(input logic lvl, output int n);
        logic [13:0] d;
        logic        p;
        n = 0;
        d = data_out;
        @(posedge clk);
        while (data_out === d && n < 50) begin
            @(posedge clk);
            n++;
        end
        p = out_clock_true;
        n = 0;
        while (!(out_clock_true === lvl && p !== lvl) && n < 50) begin
            p = out_clock_true;
            @(posedge clk);
            n++;
        end
    endtask
    task automatic tog_chk();
        logic [13:0] a, b;
        setpat(`PAT_TOGGLE);
        get(a);
        repeat (4) begin
            get(b);
            chk(16'(b), 16'(a == `WORD_TOG_A ? `WORD_TOG_B : `WORD_TOG_A));
            a = b;
        end
    endtask
    always @(posedge clk) begin
        if (sample_valid === 1'b1 && sample_ready === 1'b1) exp_q.push_back(fmt(sample_data, sbin));
        if (feed && sample_ready === 1'b0) n_full++;
        sample_valid <= feed && ($random(seed) % 8 != 0);
        sample_data  <= 12'($random(seed));
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        #380000;
        n_mismatch++;
        conclude();
    end
    initial begin
        logic [13:0] w, v;
        logic [11:0] c;
        logic [10:0] r;
        logic [2:0]  g;
        int          n0, n1;
        logic        wrapped;
        seed = 32'h43F8;
        {n_mismatch, n_tests, n_full} = '0;
        {resetn, cfg_reset, cfg_sclk, cfg_sdata, sample_valid, ddr_mode} = '0;
        {fall_edge, byte_wise, stall_en, feed, sbin} = '0;
        sample_data = 12'h000;
        cfg_sen_n = 1'b1;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        cfg_reset <= 1'b1;
        repeat (8) @(posedge clk);
        cfg_reset <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            r = 11'($random(seed)) & `MASK_LVDS;
            g = (i == 0) ? 3'h7 : 3'($random(seed));
            wr(`ADDR_LVDS, r);
            wr(`ADDR_GAIN_HI, {g, 8'h00});
            wr(5'h1F, 11'h7FF);
            chk(16'(analog_cfg), 16'({r[0], r[1], r[3:2], r[9:7], r[6:4], g}));
            chk(16'(gain_db), 16'((g == 3'h7) ? 3'h0 : g));
        end
        setpat(`PAT_ZEROS);
        get(w);
        chk(16'(w), 16'h0000);
        setpat(`PAT_ONES);
        get(w);
        chk(16'(w), 16'(`WORD_ONES));
        tog_chk();
        // Byte-wise bit set while in parallel mode must not disturb the word
        c = 12'($random(seed));
        wr(`ADDR_DDR_SEQ, 11'h400);
        wr(`ADDR_CUST_LO, {c[6:0], 4'h0});
        wr(`ADDR_GAIN_HI, {6'h00, c[11:7]});
        setpat(`PAT_CUSTOM);
        get(w);
        chk(16'(w[11:0]), 16'(c));
        setpat(`PAT_RAMP);
        get(v);
        wrapped = 1'b0;
        for (int i = 0; i < 16400; i++) begin
            get(w);
            v = v + 14'h0001;
            chk(16'(w), 16'(v));
            wrapped |= (v === 14'h0000);
            v = w;
        end
        chk(16'(wrapped), 16'h0001);
        setpat(`PAT_TOGGLE);
        phase(1'b1, n0);
        wr(`ADDR_TIMING, 11'h100);
        phase(1'b1, n1);
        chk(16'(md(n1 - n0)), 16'(`CLK_SHIFT_CYC));
        wr(`ADDR_TIMING, 11'h400);
        phase(1'b1, n1);
        chk(16'(md(n0 - n1)), 16'(2 * Q));
        wr(`ADDR_TIMING, 11'h200);
        phase(1'b0, n1);
        chk(16'(md(n1 - n0)), 16'h0000);
        fall_edge <= 1'b1;
        tog_chk();
        wr(`ADDR_TIMING, 11'h000);
        fall_edge <= 1'b0;
        ddr_mode <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            wr(`ADDR_DDR_SEQ, {b[0], 10'h000});
            byte_wise <= b[0];
            setpat(`PAT_CUSTOM);
            get(w);
            chk(16'(w[11:0]), 16'(c));
        end
        ddr_mode <= 1'b0;
        for (int b = 0; b < 2; b++) begin
            sbin <= b[0];
            wr(`ADDR_FORMAT, {b[0], 10'h000});
            stall_en <= 1'b1;
            feed <= 1'b1;
            get(w);
            for (int k = 0; k < 4 && w !== exp_q[0]; k++) get(w);
            for (int k = 0; k < 40; k++) begin
                chk(16'(w), 16'(exp_q.pop_front()));
                get(w);
            end
            feed <= 1'b0;
            stall_en <= 1'b0;
            repeat (60) @(posedge clk);
            exp_q.delete();
        end
        chk(16'(n_full > 0), 16'h0001);
        conclude();
    end
endmodule
